// >>> rtl/spsc_pkg.sv
// Constants and types shared by the port statistics counter block
package spsc_pkg;

    // ------------------------------------------------------------------
    // Register map on the AHB-Lite slave (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADDR_IAC       = 8'h00;
    localparam logic [7:0]  ADDR_DATA_LO   = 8'h04;
    localparam logic [7:0]  ADDR_DATA_HI   = 8'h08;
    localparam int          ADDR_W         = 8;

    // ------------------------------------------------------------------
    // Indirect access control word
    // ------------------------------------------------------------------
    localparam int          IAC_W          = 16;
    localparam logic [15:0] IAC_RESET      = 16'h0000;
    localparam int          IAC_RD_BIT     = 12;
    localparam int          IAC_SEL_LSB    = 10;
    localparam logic [1:0]  IAC_SEL_MIB    = 2'h3;
    localparam int          IAC_OFS_W      = 10;

    // ------------------------------------------------------------------
    // Counter word layout
    // ------------------------------------------------------------------
    localparam int          CNT_W          = 30;
    localparam int          WORD_OVF_BIT   = 31;
    localparam int          WORD_VALID_BIT = 30;
    localparam int          HALF_W         = 16;
    localparam int          DROP_W         = 16;
    localparam int          OCT_W          = 11;

    // ------------------------------------------------------------------
    // Indirect offsets
    // ------------------------------------------------------------------
    localparam int          NUM_PER_PORT   = 32;
    localparam int          NUM_PORTS      = 2;
    localparam int          NUM_CNT        = 64;
    localparam int          IDX_W          = 6;
    localparam logic [9:0]  PORT1_BASE     = 10'h000;
    localparam logic [9:0]  PORT1_LAST     = 10'h01F;
    localparam logic [9:0]  PORT2_BASE     = 10'h020;
    localparam logic [9:0]  PORT2_LAST     = 10'h03F;
    localparam int          NUM_DROP       = 4;
    localparam logic [9:0]  DROP_P1_TX     = 10'h100;
    localparam logic [9:0]  DROP_P2_TX     = 10'h101;
    localparam logic [9:0]  DROP_P1_RX     = 10'h103;
    localparam logic [9:0]  DROP_P2_RX     = 10'h104;

    // ------------------------------------------------------------------
    // Per-port counter indices
    // ------------------------------------------------------------------
    localparam logic [4:0]  IDX_RX_LOW_PRIO_OCTETS  = 5'h00;
    localparam logic [4:0]  IDX_RX_HIGH_PRIO_OCTETS = 5'h01;
    localparam logic [4:0]  IDX_RX_SHORT_GOOD_CRC   = 5'h02;
    localparam logic [4:0]  IDX_RX_SHORT_BAD        = 5'h03;
    localparam logic [4:0]  IDX_RX_LONG_GOOD_CRC    = 5'h04;
    localparam logic [4:0]  IDX_RX_LONG_BAD         = 5'h05;
    localparam logic [4:0]  IDX_RX_BAD_SYMBOL       = 5'h06;
    localparam logic [4:0]  IDX_RX_BAD_CHECK        = 5'h07;
    localparam logic [4:0]  IDX_RX_PARTIAL_BYTE_BAD = 5'h08;
    localparam logic [4:0]  IDX_RX_MAC_CTRL_FRAMES  = 5'h09;
    localparam logic [4:0]  IDX_RX_PAUSE_FRAMES     = 5'h0A;
    localparam logic [4:0]  IDX_RX_GOOD_BCAST       = 5'h0B;
    localparam logic [4:0]  IDX_RX_GOOD_MCAST       = 5'h0C;
    localparam logic [4:0]  IDX_RX_GOOD_UCAST       = 5'h0D;
    localparam logic [4:0]  IDX_RX_LEN_MIN_BUCKET   = 5'h0E;
    localparam logic [4:0]  IDX_RX_LEN_BUCKET_2     = 5'h0F;
    localparam logic [4:0]  IDX_RX_LEN_BUCKET_3     = 5'h10;
    localparam logic [4:0]  IDX_RX_LEN_BUCKET_4     = 5'h11;
    localparam logic [4:0]  IDX_RX_LEN_BUCKET_5     = 5'h12;
    localparam logic [4:0]  IDX_RX_LEN_BUCKET_6     = 5'h13;
    localparam logic [4:0]  IDX_TX_LOW_PRIO_OCTETS  = 5'h14;
    localparam logic [4:0]  IDX_TX_HIGH_PRIO_OCTETS = 5'h15;
    localparam logic [4:0]  IDX_TX_LATE_HIT         = 5'h16;
    localparam logic [4:0]  IDX_TX_PAUSE_FRAMES     = 5'h17;
    localparam logic [4:0]  IDX_TX_GOOD_BCAST       = 5'h18;
    localparam logic [4:0]  IDX_TX_GOOD_MCAST       = 5'h19;
    localparam logic [4:0]  IDX_TX_GOOD_UCAST       = 5'h1A;
    localparam logic [4:0]  IDX_TX_DELAYED_FIRST    = 5'h1B;
    localparam logic [4:0]  IDX_TX_ALL_HITS         = 5'h1C;
    localparam logic [4:0]  IDX_TX_FAILED_MANY_HITS = 5'h1D;
    localparam logic [4:0]  IDX_TX_OK_ONE_HIT       = 5'h1E;
    localparam logic [4:0]  IDX_TX_OK_SEVERAL_HITS  = 5'h1F;

    // ------------------------------------------------------------------
    // Kind of counter selected by a read command
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_PORT,
        KIND_DROP
    } spsc_kind_t;

endpackage : spsc_pkg

// >>> rtl/spsc_counter_bank.sv
// Bank of per-port clear-on-read counters with a registered read port
`timescale 1ns/10ps
module spsc_counter_bank
    import spsc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rstN,
    input  wire logic [NUM_CNT-1:0]   evt,
    input  wire logic [OCT_W-1:0]     rxOctets1,
    input  wire logic [OCT_W-1:0]     rxOctets2,
    input  wire logic [OCT_W-1:0]     txOctets1,
    input  wire logic [OCT_W-1:0]     txOctets2,
    input  wire logic                 rdEn,
    input  wire logic [IDX_W-1:0]     rdIdx,
    output logic      [CNT_W:0]       rdData
);

    // ------------------------------------------------------------------
    // Increment per counter
    // ------------------------------------------------------------------
    function automatic logic [CNT_W-1:0] incAmount(
        input logic [4:0]       idx,
        input logic             hit,
        input logic [OCT_W-1:0] rxOct,
        input logic [OCT_W-1:0] txOct
    );
        logic [CNT_W-1:0] amt;
        amt = '0;
        unique case (idx)
            IDX_RX_LOW_PRIO_OCTETS,
            IDX_RX_HIGH_PRIO_OCTETS:
                amt = {{(CNT_W-OCT_W){1'b0}}, rxOct};
            IDX_TX_LOW_PRIO_OCTETS,
            IDX_TX_HIGH_PRIO_OCTETS:
                amt = {{(CNT_W-OCT_W){1'b0}}, txOct};
            IDX_RX_SHORT_GOOD_CRC, IDX_RX_SHORT_BAD,
            IDX_RX_LONG_GOOD_CRC:              amt = 30'h1;
            IDX_RX_LONG_BAD:                   amt = 30'h1;
            IDX_RX_BAD_SYMBOL, IDX_RX_BAD_CHECK,
            IDX_RX_PARTIAL_BYTE_BAD:           amt = 30'h1;
            IDX_RX_MAC_CTRL_FRAMES,
            IDX_RX_PAUSE_FRAMES:               amt = 30'h1;
            IDX_RX_GOOD_BCAST, IDX_RX_GOOD_MCAST,
            IDX_RX_GOOD_UCAST:                 amt = 30'h1;
            IDX_RX_LEN_MIN_BUCKET, IDX_RX_LEN_BUCKET_2,
            IDX_RX_LEN_BUCKET_3, IDX_RX_LEN_BUCKET_4,
            IDX_RX_LEN_BUCKET_5, IDX_RX_LEN_BUCKET_6:
                                               amt = 30'h1;
            IDX_TX_LATE_HIT, IDX_TX_PAUSE_FRAMES:
                                               amt = 30'h1;
            IDX_TX_GOOD_BCAST, IDX_TX_GOOD_MCAST,
            IDX_TX_GOOD_UCAST:                 amt = 30'h1;
            IDX_TX_DELAYED_FIRST, IDX_TX_ALL_HITS,
            IDX_TX_FAILED_MANY_HITS, IDX_TX_OK_ONE_HIT,
            IDX_TX_OK_SEVERAL_HITS:            amt = 30'h1;
        endcase
        return hit ? amt : '0;
    endfunction : incAmount

    // ------------------------------------------------------------------
    // Counters: bit CNT_W is the sticky overflow flag
    // ------------------------------------------------------------------
    logic [CNT_W:0]   cntQ [NUM_CNT];
    logic [CNT_W-1:0] amt  [NUM_CNT];

    genvar g;
    generate
        for (g = 0; g < NUM_CNT; g++) begin : g_cnt
            logic [CNT_W:0] sum;
            logic           hitRd;
            assign amt[g] = incAmount(5'(g % NUM_PER_PORT), evt[g],
                                      (g < NUM_PER_PORT) ? rxOctets1
                                                         : rxOctets2,
                                      (g < NUM_PER_PORT) ? txOctets1
                                                         : txOctets2);
            assign sum   = {1'b0, cntQ[g][CNT_W-1:0]} + {1'b0, amt[g]};
            assign hitRd = rdEn && (rdIdx == IDX_W'(g));
            always_ff @(posedge clk or negedge rstN) begin
                if (!rstN) begin
                    cntQ[g] <= '0;
                end else if (hitRd) begin
                    // Restart with this cycle's increment so it is kept
                    cntQ[g] <= {1'b0, amt[g]};
                end else begin
                    cntQ[g] <= {cntQ[g][CNT_W] | sum[CNT_W],
                                sum[CNT_W-1:0]};
                end
            end

            a_ovf_sticky: assert property (
                @(posedge clk) disable iff (!rstN)
                cntQ[g][CNT_W] && !hitRd |=> cntQ[g][CNT_W])
                else $error("overflow flag dropped without a read");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Registered read port, captured in the clearing cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdData <= '0;
        end else if (rdEn) begin
            rdData <= cntQ[rdIdx];
        end
    end

    a_read_captures: assert property (
        @(posedge clk) disable iff (!rstN)
        rdEn |=> rdData == $past(cntQ[rdIdx]))
        else $error("read data is not the pre-clear count");
    a_read_clears: assert property (
        @(posedge clk) disable iff (!rstN)
        rdEn |=> cntQ[$past(rdIdx)] == {1'b0, $past(amt[rdIdx])})
        else $error("counter not cleared by its read");
    c_overflow_seen: cover property (@(posedge clk) disable iff (!rstN)
        rdEn && cntQ[rdIdx][CNT_W]);

endmodule : spsc_counter_bank

// >>> rtl/spsc_statistics.sv
// Port statistics counters with indirect access over AHB-Lite
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
module spsc_statistics
    import spsc_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic [NUM_PER_PORT-1:0] port1Evt,
    input  wire logic [NUM_PER_PORT-1:0] port2Evt,
    input  wire logic [OCT_W-1:0]     rxOctets1,
    input  wire logic [OCT_W-1:0]     rxOctets2,
    input  wire logic [OCT_W-1:0]     txOctets1,
    input  wire logic [OCT_W-1:0]     txOctets2,
    input  wire logic [NUM_DROP-1:0]  dropEvt
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rstMetaQ;
    logic rstN;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rstMetaQ <= 1'b0;
            rstN     <= 1'b0;
        end else begin
            rstMetaQ <= 1'b1;
            rstN     <= rstMetaQ;
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------------
    logic              busAcc;
    logic              wrPendQ;
    logic [ADDR_W-1:0] wrAddrQ;
    logic [IAC_W-1:0]  iacQ;
    logic [31:0]       dataWordQ;
    logic              validQ;
    logic [31:0]       rdMux;
    logic [HALF_W-1:0] dataHi;
    logic              iacWrite;

    assign busAcc   = hsel && hready && htrans[1];
    assign iacWrite = wrPendQ && (wrAddrQ == ADDR_IAC);
    assign dataHi   = {dataWordQ[WORD_OVF_BIT], validQ,
                       dataWordQ[WORD_VALID_BIT-1:HALF_W]};

    always_comb begin
        rdMux = '0;
        unique case (haddr[ADDR_W-1:0])
            ADDR_IAC:     rdMux = {16'h0000, iacQ};
            ADDR_DATA_LO: rdMux = {16'h0000, dataWordQ[HALF_W-1:0]};
            ADDR_DATA_HI: rdMux = {16'h0000, dataHi};
            default:      rdMux = '0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            wrPendQ <= 1'b0;
            wrAddrQ <= '0;
        end else begin
            wrPendQ <= busAcc && hwrite;
            if (busAcc && hwrite) begin
                wrAddrQ <= haddr[ADDR_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            hrdata <= '0;
        end else if (busAcc && !hwrite) begin
            hrdata <= rdMux;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Indirect access control and command decode
    // ------------------------------------------------------------------
    logic                 cmdQ;
    logic                 loadQ;
    spsc_kind_t           cmdKind;
    spsc_kind_t           loadKindQ;
    logic [IAC_OFS_W-1:0] ofs;
    logic [1:0]           dropSel;
    logic                 cmdIsMib;

    assign ofs      = iacQ[IAC_OFS_W-1:0];
    assign cmdIsMib = hwdata[IAC_RD_BIT]
                   && (hwdata[IAC_SEL_LSB+1:IAC_SEL_LSB] == IAC_SEL_MIB);

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            iacQ <= IAC_RESET;
            cmdQ <= 1'b0;
        end else begin
            cmdQ <= iacWrite && cmdIsMib;
            if (iacWrite) begin
                iacQ <= hwdata[IAC_W-1:0];
            end
        end
    end

    always_comb begin
        cmdKind = KIND_NONE;
        dropSel = 2'h0;
        if (ofs <= PORT1_LAST) begin
            cmdKind = KIND_PORT;
        end else if (ofs >= PORT2_BASE && ofs <= PORT2_LAST) begin
            cmdKind = KIND_PORT;
        end else begin
            unique case (ofs)
                DROP_P1_TX: begin
                    cmdKind = KIND_DROP;
                    dropSel = 2'h0;
                end
                DROP_P2_TX: begin
                    cmdKind = KIND_DROP;
                    dropSel = 2'h1;
                end
                DROP_P1_RX: begin
                    cmdKind = KIND_DROP;
                    dropSel = 2'h2;
                end
                DROP_P2_RX: begin
                    cmdKind = KIND_DROP;
                    dropSel = 2'h3;
                end
                default: cmdKind = KIND_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Per-port counter bank
    // ------------------------------------------------------------------
    logic [CNT_W:0] bankData;
    logic           bankRd;

    assign bankRd = cmdQ && (cmdKind == KIND_PORT);

    spsc_counter_bank u_bank (
        .clk       (ref_clk),
        .rstN      (rstN),
        .evt       ({port2Evt, port1Evt}),
        .rxOctets1 (rxOctets1),
        .rxOctets2 (rxOctets2),
        .txOctets1 (txOctets1),
        .txOctets2 (txOctets2),
        .rdEn      (bankRd),
        .rdIdx     (ofs[IDX_W-1:0]),
        .rdData    (bankData)
    );

    // ------------------------------------------------------------------
    // Dropped-packet counters, free running and cleared only by reset, not by a read
    // ------------------------------------------------------------------
    logic [DROP_W-1:0] dropCntQ [NUM_DROP];
    logic [DROP_W-1:0] dropRdQ;

    genvar d;
    generate
        for (d = 0; d < NUM_DROP; d++) begin : g_drop
            always_ff @(posedge ref_clk or negedge rstN) begin
                if (!rstN) begin
                    dropCntQ[d] <= '0;
                end else if (dropEvt[d]) begin
                    dropCntQ[d] <= dropCntQ[d] + 16'h0001;
                end
            end

            a_drop_unchanged: assert property (
                @(posedge ref_clk) disable iff (!rstN)
                ##1 dropCntQ[d] == $past(dropCntQ[d])
                        + DROP_W'($past(dropEvt[d])))
                else $error("dropped counter moved without an event");
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            dropRdQ <= '0;
        end else if (cmdQ && (cmdKind == KIND_DROP)) begin
            dropRdQ <= dropCntQ[dropSel];
        end
    end

    // ------------------------------------------------------------------
    // Data register load and validity
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            loadQ     <= 1'b0;
            loadKindQ <= KIND_NONE;
        end else begin
            loadQ     <= cmdQ;
            loadKindQ <= cmdKind;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            dataWordQ <= '0;
        end else if (loadQ) begin
            unique case (loadKindQ)
                KIND_PORT: dataWordQ <= {bankData[CNT_W], 1'b0,
                                         bankData[CNT_W-1:0]};
                KIND_DROP: dataWordQ <= {16'h0000, dropRdQ};
                KIND_NONE: dataWordQ <= '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            validQ <= 1'b0;
        end else if (iacWrite && cmdIsMib) begin
            validQ <= 1'b0;
        end else if (loadQ) begin
            validQ <= (loadKindQ == KIND_PORT);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstN);

    a_port_valid_time: assert property (
        bankRd |-> !validQ ##1 !validQ ##1 validQ)
        else $error("valid flag not set two cycles after capture");
    a_drop_no_flags: assert property (
        cmdQ && cmdKind == KIND_DROP |=> ##1 dataHi == 16'h0000)
        else $error("dropped counter word shows flags or high bits");
    a_port_word_split: assert property (
        loadQ && loadKindQ == KIND_PORT |=>
            {dataHi[HALF_W-1], dataHi[HALF_W-3:0],
             dataWordQ[HALF_W-1:0]} == $past(bankData))
        else $error("counter word not split over high and low");
    a_hi_read_data: assert property (
        busAcc && !hwrite && haddr[ADDR_W-1:0] == ADDR_DATA_HI |=>
            hrdata == {16'h0000, $past(dataHi)})
        else $error("high data register read wrong");
    a_iac_readback: assert property (
        iacWrite |=> iacQ == $past(hwdata[IAC_W-1:0]))
        else $error("control register did not take the write");
    a_cmd_clears_valid: assert property (
        iacWrite && cmdIsMib |=> !validQ)
        else $error("valid flag survived a new read command");
    a_unmapped_zero: assert property (
        loadQ && loadKindQ == KIND_NONE |=> dataWordQ == 32'h0 && !validQ)
        else $error("unmapped offset loaded data or set valid");
    a_drop_word: assert property (
        cmdQ && cmdKind == KIND_DROP |=> ##1
            dataWordQ == {16'h0000, $past(dropCntQ[dropSel], 2)})
        else $error("dropped counter word differs from its count");
    a_drop_never_valid: assert property (
        loadQ && loadKindQ == KIND_DROP |=> !validQ)
        else $error("dropped counter word flagged valid");
    a_port_range: assert property (
        cmdQ && ofs <= PORT2_LAST |-> bankRd)
        else $error("offset in port range did not read the bank");
    a_overflow_word: assert property (
        loadQ && loadKindQ == KIND_PORT |=>
            dataHi[HALF_W-1] == $past(bankData[CNT_W]))
        else $error("overflow flag not shown in bit 31");

    // ------------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------------
    a_bus_ready: assert property ($past(rstN) |-> hreadyout)
        else $error("slave not ready after reset");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("slave response not OKAY");
    a_lo_read_data: assert property (
        busAcc && !hwrite && haddr[ADDR_W-1:0] == ADDR_DATA_LO |=>
            hrdata == {16'h0000, $past(dataWordQ[HALF_W-1:0])})
        else $error("low data register read wrong");
    a_iac_read: assert property (
        busAcc && !hwrite && haddr[ADDR_W-1:0] == ADDR_IAC |=>
            hrdata == {16'h0000, $past(iacQ)})
        else $error("control register read wrong");
    a_data_read_only: assert property (
        wrPendQ && !iacWrite && !loadQ |=> $stable(dataWordQ))
        else $error("data register changed by a bus write");

    // ------------------------------------------------------------------
    // Scenario covers
    // ------------------------------------------------------------------
    c_unmapped:   cover property (loadQ && loadKindQ == KIND_NONE);
    c_port_read:  cover property (bankRd ##2 validQ);
    c_drop_read:  cover property (cmdQ && cmdKind == KIND_DROP);
    c_reread_hi:  cover property (busAcc && !hwrite && !validQ
                                  && haddr[ADDR_W-1:0] == ADDR_DATA_HI);

endmodule : spsc_statistics

// >>> testbench/switch_port_statistics_counters_tb_top.sv
// Self-checking bench for the port statistics counter block
`timescale 1ns/10ps
module switch_port_statistics_counters_tb_top import spsc_pkg::*;;
    logic                    refClk, nrst, hsel, hwrite, hreadyout, hresp;
    logic [31:0]             haddr, hwdata, hrdata, w, e;
    logic [1:0]              htrans;
    logic [NUM_PER_PORT-1:0] p1Evt, p2Evt;
    logic [OCT_W-1:0]        rxO, txO;
    logic [NUM_DROP-1:0]     dropEvt;
    logic [9:0]              dOff [4];
    int                      failCount, nCompared, k;

    spsc_statistics dut (.ref_clk(refClk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .port1Evt(p1Evt),
        .port2Evt(p2Evt), .rxOctets1(rxO), .rxOctets2(rxO),
        .txOctets1(txO), .txOctets2(txO), .dropEvt(dropEvt));

    initial begin
        refClk = 1'b0;
        forever #20 refClk = ~refClk;
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic finishTest();
        if (failCount == 0 && nCompared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finishTest

    task automatic cmp(string name, logic [31:0] ex, logic [31:0] got);
        nCompared++;
        if (got !== ex) begin
            failCount++;
            $display("BAD %s exp %h got %h", name, ex, got);
        end
    endtask : cmp

    // Ends one bus phase at the rising edge after the first falling edge that sees hready high
    task automatic step(output logic [31:0] r);
        int n;
        for (n = 0; n < 20; n++) begin
            @(negedge refClk);
            r = hrdata;
            if (hreadyout === 1'b1) break;
        end
        cmp("response", 32'h0, {31'h0, hresp});
        @(posedge refClk);
        if (n == 20) begin
            failCount++;
            finishTest();
        end
    endtask : step

    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        step(r);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        step(r);
    endtask : bus

    // Fetch the loaded word, retry the high half until valid
    task automatic fetch(int tries, output logic [31:0] v);
        logic [31:0] hi, lo;
        bus(1'b0, ADDR_DATA_HI, 32'h0, hi);
        for (int n = 1; n < tries && hi[14] !== 1'b1; n++)
            bus(1'b0, ADDR_DATA_HI, 32'h0, hi);
        bus(1'b0, ADDR_DATA_LO, 32'h0, lo);
        v = {hi[15:0], lo[15:0]};
    endtask : fetch

    // Command a counter read, then fetch its word
    task automatic cnt(logic [15:0] cmd, int tries, output logic [31:0] v);
        logic [31:0] lo;
        bus(1'b1, ADDR_IAC, {16'h0, cmd}, lo);
        fetch(tries, v);
    endtask : cnt

    task automatic pulse(logic [31:0] m1, m2, logic [3:0] md, int n);
        p1Evt   <= m1;
        p2Evt   <= m2;
        dropEvt <= md;
        repeat (n) @(posedge refClk);
        {p1Evt, p2Evt, dropEvt} <= '0;
    endtask : pulse

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {p1Evt, p2Evt, dropEvt} = '0;
        rxO = 11'h7FF;
        txO = 11'h40C;
        dOff = '{DROP_P1_TX, DROP_P2_TX, DROP_P1_RX, DROP_P2_RX};
        repeat (10) @(posedge refClk);
        nrst <= 1'b1;
        for (k = 0; k < 10 && hreadyout !== 1'b1; k++) @(negedge refClk);
        if (k == 10) begin
            failCount++;
            finishTest();
        end
        @(posedge refClk);
        bus(1'b0, ADDR_IAC, 32'h0, w);
        cmp("control reset", 32'h0, w);
        pulse(32'h1 << 14, 32'h0, 4'h0, 1);
        bus(1'b1, ADDR_IAC, 32'h1C0E, w);
        bus(1'b0, ADDR_DATA_HI, 32'h0, w);
        cmp("early valid", 32'h0, {31'h0, w[14]});
        fetch(8, w);
        cmp("counter", 32'h4000_0001, w);
        cnt(16'h1C0E, 8, w);
        cmp("cleared", 32'h4000_0000, w);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < NUM_PER_PORT; i++) begin
                e = (i < 2) ? 32'h13FD8
                  : (i == 20 || i == 21) ? 32'hA1E0 : 32'h28;
                pulse(p == 0 ? 32'h1 << i : 32'h0, p == 1 ? 32'h1 << i : 32'h0,
                      4'h0, 40);
                cnt(16'h1C00 | 16'(p * 32 + i), 8, w);
                cmp("counter", 32'h4000_0000 | e, w);
                cnt(16'h1C00 | 16'(p * 32 + i), 8, w);
                cmp("cleared", 32'h4000_0000, w);
            end
        end
        for (int d = 0; d < NUM_DROP; d++) begin
            pulse(32'h0, 32'h0, 4'h1 << d, d + 5);
            cnt(16'h1C00 | 16'(dOff[d]), 3, w);
            cmp("drop", 32'(d + 5), w);
            cnt(16'h1C00 | 16'(dOff[d]), 3, w);
            cmp("drop kept", 32'(d + 5), w);
        end
        bus(1'b1, ADDR_DATA_LO, 32'hFFFF, w);
        bus(1'b0, ADDR_DATA_LO, 32'h0, w);
        cmp("read only low", 32'h8, w);
        cnt(16'h1C40, 3, w);
        cmp("unmapped offset", 32'h0, w);
        bus(1'b0, ADDR_IAC, 32'h0, w);
        cmp("control", 32'h1C40, w);
        bus(1'b0, 8'h0C, 32'h0, w);
        cmp("unmapped addr", 32'h0, w);
        finishTest();
    end
endmodule : switch_port_statistics_counters_tb_top
